// file: cfhr_pkg.sv
package cfhr_pkg;

  // Register offsets on the control port
  localparam logic [7:0] CFHR_FILT_OFS  = 8'h0c;
  localparam logic [7:0] CFHR_DETA_OFS  = 8'h0d;
  localparam logic [7:0] CFHR_DETB_OFS  = 8'h0e;
  localparam logic [7:0] CFHR_UNMAPPED  = 8'h00;

  // Values after reset
  localparam logic [7:0] CFHR_FILT_RST  = 8'h00;
  localparam logic [1:0] CFHR_TYPE_RST  = 2'h0;
  localparam logic [2:0] CFHR_JDEB_RST  = 3'h0;
  localparam logic [1:0] CFHR_BDEB_RST  = 2'h0;
  localparam logic [2:0] CFHR_DRV_RST   = 3'h0;

  // Field positions, detection register A
  localparam int CFHR_A_EN    = 7;
  localparam int CFHR_A_TYPE  = 5;
  localparam int CFHR_A_JDEB  = 2;
  localparam int CFHR_A_BDEB  = 0;
  // Field positions, detection register B
  localparam int CFHR_B_CAP   = 7;
  localparam int CFHR_B_FDIFF = 6;
  localparam int CFHR_B_BTN   = 5;
  localparam int CFHR_B_HS    = 4;
  localparam int CFHR_B_PDIFF = 3;
  localparam logic [2:0] CFHR_B_RSVD = 3'h0;

  // Headset type codes
  localparam logic [1:0] CFHR_HS_NONE  = 2'h0;
  localparam logic [1:0] CFHR_HS_NOMIC = 2'h1;
  localparam logic [1:0] CFHR_HS_MIC   = 2'h3;

  // Debounce codes
  localparam logic [2:0] CFHR_JDEB_MAX = 3'h5;
  localparam logic [1:0] CFHR_BDEB_OFF = 2'h0;

  // Time base: one millisecond at the core clock
  localparam int unsigned CFHR_CLK_PERIOD_PS = 4000;
  localparam int unsigned CFHR_MS_TIME_PS    = 1000000000;
  localparam int unsigned CFHR_MS_CYCLES     = CFHR_MS_TIME_PS / CFHR_CLK_PERIOD_PS;
  localparam int          CFHR_TICKS         = 7;
  // Every interval is eight sampling ticks long
  localparam logic [3:0]  CFHR_DEB_SAMPLES   = 4'h8;

endpackage : cfhr_pkg

// file: cfhr_tick.sv
`timescale 1ns/1ps
module cfhr_tick
  import cfhr_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CFHR_MS_CYCLES
) (
  input  wire logic                  clk,  // Core clock
  input  wire logic                  rst,  // Synchronous reset
  output logic      [CFHR_TICKS-1:0] tick  // Pulse every 2**k ms
);

  logic [31:0] div_r;
  logic [5:0]  ms_r;
  logic        ms_w;

  assign ms_w = (div_r == 32'(MS_CYCLES - 1));

  // Millisecond divider and binary ms counter
  always_ff @(posedge clk) begin
    if (rst || ms_w) begin
      div_r <= 32'h0;
    end else begin
      div_r <= div_r + 32'h1;
    end
    if (rst) begin
      ms_r <= 6'h0;
    end else if (ms_w) begin
      ms_r <= ms_r + 6'h1;
    end
  end

  // Power-of-two ticks share one counter so they stay phase aligned
  always_comb begin
    tick[0] = ms_w;
    for (int k = 1; k < CFHR_TICKS; k++) begin
      tick[k] = ms_w && ((ms_r & 6'((1 << k) - 1)) == 6'h0);
    end
  end

endmodule : cfhr_tick

// file: cfhr_debounce.sv
`timescale 1ns/1ps
module cfhr_debounce
  import cfhr_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,     // Core clock
  input  wire logic         rst,     // Synchronous reset
  input  wire logic         clr,     // Hold idle, output zero
  input  wire logic         tick,    // Sampling tick
  input  wire logic         bypass,  // No debounce, follow input
  input  wire logic [W-1:0] din,     // Raw level
  output logic      [W-1:0] dout     // Debounced level
);

  logic [W-1:0] cand_r;
  logic [3:0]   cnt_r;

  // A level is accepted only after eight equal samples in a row
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      cand_r <= '0;
      cnt_r  <= 4'h0;
      dout   <= '0;
    end else if (bypass) begin
      cand_r <= din;
      cnt_r  <= 4'h0;
      dout   <= din;
    end else if (tick) begin
      if (din != cand_r) begin
        cand_r <= din;
        cnt_r  <= 4'h1;
      end else if (cnt_r != CFHR_DEB_SAMPLES) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r + 4'h1 == CFHR_DEB_SAMPLES) begin
          dout <= cand_r;
        end
      end
    end
  end

endmodule : cfhr_debounce

// file: cfhr_regs.sv
`timescale 1ns/1ps
module cfhr_regs
  import cfhr_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CFHR_MS_CYCLES
) (
  input  wire logic       clk,             // Core clock, 250 MHz
  input  wire logic       rst,             // Synchronous reset, active high
  input  wire logic [7:0] reg_addr,        // Register offset
  input  wire logic       reg_wr,          // Write strobe
  input  wire logic [7:0] reg_wdata,       // Write data
  input  wire logic       reg_rd,          // Read strobe
  output logic      [7:0] reg_rdata,       // Read data
  output logic            reg_rvalid,      // Read data valid pulse
  input  wire logic       jack_in,         // Headset plug sensed
  input  wire logic       jack_mic,        // Microphone sensed on plug
  input  wire logic       button_in,       // Button level sensed
  output logic      [1:0] adc_hpf_left,    // Left ADC high-pass select
  output logic      [1:0] adc_hpf_right,   // Right ADC high-pass select
  output logic            dac_fx_left,     // Left DAC effects enable
  output logic            dac_deemph_left, // Left DAC de-emphasis enable
  output logic            dac_fx_right,    // Right DAC effects enable
  output logic            dac_deemph_right,// Right DAC de-emphasis enable
  output logic            drv_ac_coupled,  // High-power outputs ac-coupled
  output logic            drv_full_diff,   // Fully differential outputs
  output logic            drv_pseudo_diff, // Pseudodifferential outputs
  output logic      [1:0] headset_type,    // Detected headset type
  output logic            headset_flag,    // Headset present
  output logic            button_flag      // Sticky button press
);

  // Pick one tick of the power-of-two set
  function automatic logic tick_pick(input logic [CFHR_TICKS-1:0] t,
                                     input logic [2:0]            idx);
    tick_pick = t[idx];
  endfunction : tick_pick

  // Software state
  logic [7:0] filt_r;
  logic       det_en_r;
  logic [2:0] jdeb_r;
  logic [1:0] bdeb_r;
  logic       cap_r;
  logic       fdiff_r;
  logic       pdiff_r;
  // Hardware state
  logic [1:0] type_r;
  logic       hs_r;
  logic       btn_r;
  logic       btn_prev_r;
  logic [7:0] rdata_r;
  logic       rvalid_r;

  // Address decode
  logic hit_filt_w;
  logic hit_deta_w;
  logic hit_detb_w;
  assign hit_filt_w = (reg_addr == CFHR_FILT_OFS);
  assign hit_deta_w = (reg_addr == CFHR_DETA_OFS);
  assign hit_detb_w = (reg_addr == CFHR_DETB_OFS);

  logic wr_filt_w;
  logic wr_deta_w;
  logic wr_detb_w;
  logic rd_detb_w;
  assign wr_filt_w = reg_wr && hit_filt_w;
  assign wr_deta_w = reg_wr && hit_deta_w;
  assign wr_detb_w = reg_wr && hit_detb_w;
  assign rd_detb_w = reg_rd && hit_detb_w;

  // Read views of the three registers
  logic [7:0] view_filt_w;
  logic [7:0] view_deta_w;
  logic [7:0] view_detb_w;
  logic [7:0] rd_mux_w;
  assign view_filt_w = filt_r;
  assign view_deta_w = {det_en_r, type_r, jdeb_r, bdeb_r};
  assign view_detb_w = {cap_r, fdiff_r, btn_r, hs_r, pdiff_r, CFHR_B_RSVD};

  always_comb begin
    if (hit_filt_w) begin
      rd_mux_w = view_filt_w;
    end else if (hit_deta_w) begin
      rd_mux_w = view_deta_w;
    end else if (hit_detb_w) begin
      rd_mux_w = view_detb_w;
    end else begin
      rd_mux_w = CFHR_UNMAPPED;
    end
  end

  // Time base
  logic [CFHR_TICKS-1:0] ticks_w;

  cfhr_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (ticks_w)
  );

  // Tick selection; reserved jack codes clamp to the longest interval
  logic [2:0] jidx_w;
  logic [2:0] bidx_w;
  logic       jtick_w;
  logic       btick_w;
  assign jidx_w  = (jdeb_r > CFHR_JDEB_MAX) ? CFHR_JDEB_MAX + 3'h1 : jdeb_r + 3'h1;
  // Code 00 bypasses the debouncer; keep its tick index in range anyway
  assign bidx_w  = (bdeb_r == CFHR_BDEB_OFF) ? 3'h0 : {1'b0, bdeb_r} - 3'h1;
  assign jtick_w = tick_pick(ticks_w, jidx_w);
  assign btick_w = tick_pick(ticks_w, bidx_w);

  // Detection idles while disabled
  logic det_idle_w;
  assign det_idle_w = !det_en_r;

  logic [1:0] jack_deb_w;
  logic       btn_deb_w;

  cfhr_debounce #(
    .W (2)
  ) u_jack (
    .clk    (clk),
    .rst    (rst),
    .clr    (det_idle_w),
    .tick   (jtick_w),
    .bypass (1'b0),
    .din    ({jack_in, jack_mic}),
    .dout   (jack_deb_w)
  );

  // A press only counts with a headset present
  cfhr_debounce #(
    .W (1)
  ) u_button (
    .clk    (clk),
    .rst    (rst),
    .clr    (det_idle_w || !hs_r),
    .tick   (btick_w),
    .bypass (bdeb_r == CFHR_BDEB_OFF),
    .din    (button_in),
    .dout   (btn_deb_w)
  );

  // Type code from the debounced plug and mic levels
  logic [1:0] type_nxt;
  assign type_nxt = !jack_deb_w[1] ? CFHR_HS_NONE :
                    (jack_deb_w[0] ? CFHR_HS_MIC : CFHR_HS_NOMIC);

  logic press_w;
  assign press_w = btn_deb_w && !btn_prev_r;

  // Filter control register
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_r <= CFHR_FILT_RST;
    end else if (wr_filt_w) begin
      filt_r <= reg_wdata;
    end
  end

  // Detection register A, writable fields
  always_ff @(posedge clk) begin
    if (rst) begin
      det_en_r <= 1'b0;
      jdeb_r   <= CFHR_JDEB_RST;
      bdeb_r   <= CFHR_BDEB_RST;
    end else if (wr_deta_w) begin
      det_en_r <= reg_wdata[CFHR_A_EN];
      jdeb_r   <= reg_wdata[CFHR_A_JDEB +: 3];
      bdeb_r   <= reg_wdata[CFHR_A_BDEB +: 2];
    end
  end

  // Detection register B, driver configuration; read-only bits ignore writes
  always_ff @(posedge clk) begin
    if (rst) begin
      {cap_r, fdiff_r, pdiff_r} <= CFHR_DRV_RST;
    end else if (wr_detb_w) begin
      cap_r   <= reg_wdata[CFHR_B_CAP];
      fdiff_r <= reg_wdata[CFHR_B_FDIFF];
      pdiff_r <= reg_wdata[CFHR_B_PDIFF];
    end
  end

  // Results follow the debouncer, so they move only on settled levels
  always_ff @(posedge clk) begin
    if (rst) begin
      type_r     <= CFHR_TYPE_RST;
      hs_r       <= 1'b0;
      btn_prev_r <= 1'b0;
    end else begin
      type_r     <= type_nxt;
      hs_r       <= jack_deb_w[1];
      btn_prev_r <= btn_deb_w;
    end
  end

  // Sticky press flag: a press in the read cycle wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      btn_r <= 1'b0;
    end else if (press_w) begin
      btn_r <= 1'b1;
    end else if (rd_detb_w) begin
      btn_r <= 1'b0;
    end
  end

  // Registered read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        rdata_r <= rd_mux_w;
      end
    end
  end

  // Outputs straight from flops
  assign reg_rdata        = rdata_r;
  assign reg_rvalid       = rvalid_r;
  assign adc_hpf_left     = filt_r[7:6];
  assign adc_hpf_right    = filt_r[5:4];
  assign dac_fx_left      = filt_r[3];
  assign dac_deemph_left  = filt_r[2];
  assign dac_fx_right     = filt_r[1];
  assign dac_deemph_right = filt_r[0];
  assign drv_ac_coupled   = cap_r;
  assign drv_full_diff    = fdiff_r;
  assign drv_pseudo_diff  = pdiff_r;
  assign headset_type     = type_r;
  assign headset_flag     = hs_r;
  assign button_flag      = btn_r;

endmodule : cfhr_regs

// file: cfhr_regs_assertions.sv
`timescale 1ns/1ps
module cfhr_regs_assertions
  import cfhr_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CFHR_MS_CYCLES
) (
  input wire logic       clk,              // Core clock
  input wire logic       rst,              // Synchronous reset
  input wire logic [7:0] reg_addr,         // Offset
  input wire logic       reg_wr,           // Write strobe
  input wire logic [7:0] reg_wdata,        // Write data
  input wire logic       reg_rd,           // Read strobe
  input wire logic [7:0] reg_rdata,        // Read data
  input wire logic       reg_rvalid,       // Read valid
  input wire logic [1:0] adc_hpf_left,     // Left high-pass
  input wire logic [1:0] adc_hpf_right,    // Right high-pass
  input wire logic       dac_fx_left,      // Left effects
  input wire logic       dac_deemph_left,  // Left de-emphasis
  input wire logic       dac_fx_right,     // Right effects
  input wire logic       dac_deemph_right, // Right de-emphasis
  input wire logic       drv_ac_coupled,   // Coupling
  input wire logic       drv_full_diff,    // Fully differential
  input wire logic       drv_pseudo_diff,  // Pseudodifferential
  input wire logic [1:0] headset_type,     // Type result
  input wire logic       headset_flag,     // Headset present
  input wire logic       button_flag       // Sticky press
);
  // Register images rebuilt from the decoded outputs
  wire [7:0] filt_w = {adc_hpf_left, adc_hpf_right, dac_fx_left, dac_deemph_left,
                       dac_fx_right, dac_deemph_right};
  wire [2:0] drv_w  = {drv_ac_coupled, drv_full_diff, drv_pseudo_diff};
  wire [2:0] wdrv_w = {reg_wdata[7], reg_wdata[6], reg_wdata[3]};
  wire       unmap_w = reg_rd && (reg_addr < CFHR_FILT_OFS || reg_addr > CFHR_DETB_OFS);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd(a); reg_rd && reg_addr == a; endsequence
  sequence s_wr(a); reg_wr && reg_addr == a; endsequence

  chk_rvalid_pulse: assert property (1'b1 |=> reg_rvalid == $past(reg_rd))
    else $error("read valid does not follow read strobe");
  chk_filt_write: assert property (s_wr(CFHR_FILT_OFS) |=> filt_w == $past(reg_wdata))
    else $error("filter outputs differ from written byte");
  chk_filt_hold: assert property (!(reg_wr && reg_addr == CFHR_FILT_OFS) |=> $stable(filt_w))
    else $error("filter outputs changed without a write");
  chk_drv_write: assert property (s_wr(CFHR_DETB_OFS) |=> drv_w == $past(wdrv_w))
    else $error("driver bits differ from written byte");
  chk_filt_read: assert property (s_rd(CFHR_FILT_OFS) |=> reg_rdata == $past(filt_w))
    else $error("filter readback wrong");
  chk_detb_read: assert property (s_rd(CFHR_DETB_OFS) |=> reg_rdata ==
    {$past(drv_w[2:1]), $past(button_flag), $past(headset_flag), $past(drv_w[0]), 3'h0})
    else $error("detection B readback wrong");
  chk_deta_read: assert property (s_rd(CFHR_DETA_OFS) |=> reg_rdata[6:5] == $past(headset_type))
    else $error("type field readback wrong");
  chk_unmapped_zero: assert property (unmap_w |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_btn_sticky: assert property (button_flag && !(reg_rd && reg_addr == CFHR_DETB_OFS) |=> button_flag)
    else $error("button flag dropped without read");
  chk_type_code: assert property (headset_type != 2'h2)
    else $error("reserved type code shown");
  chk_flag_rise: assert property ($rose(headset_flag) |-> headset_type != CFHR_HS_NONE)
    else $error("headset flag without type");
endmodule : cfhr_regs_assertions

bind cfhr_regs cfhr_regs_assertions #(.MS_CYCLES(MS_CYCLES)) chk_u (.*);

// file: cfhr_jack_model.sv
`timescale 1ns/1ps
module cfhr_jack_model (
  input  wire logic clk,               // Core clock
  input  wire logic plug,              // Plug inserted
  input  wire logic mic,               // Plug carries a microphone
  input  wire logic press,             // Button held
  output logic      jack_in   = 1'b0,  // Plug contact
  output logic      jack_mic  = 1'b0,  // Mic contact
  output logic      button_in = 1'b0   // Button contact
);
  // Mic and button sit on the cable, so they read low with nothing plugged
  always @(posedge clk) begin
    jack_in   <= plug;
    jack_mic  <= plug & mic;
    button_in <= plug & press;
  end
endmodule : cfhr_jack_model

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  import cfhr_pkg::*;
  localparam int unsigned MS = 10;  // Short millisecond keeps the run brief
  logic       clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, plug = 0, mic = 0, press = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, v, e;
  logic       reg_rvalid, jack_in, jack_mic, button_in, dac_fx_left, dac_deemph_left;
  logic       dac_fx_right, dac_deemph_right, drv_ac_coupled, drv_full_diff;
  logic       drv_pseudo_diff, headset_flag, button_flag;
  logic [1:0] adc_hpf_left, adc_hpf_right, headset_type;
  int         fail_count = 0, tests_run = 0, cycles = 0, seed = 87, k, t;

  always #2 clk = ~clk;
  // Hang guard, well above the longest debounce sweep
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      summarize();
    end
  end

  cfhr_regs #(.MS_CYCLES(MS)) dut_u (.*);
  cfhr_jack_model jack_u (.clk(clk), .plug(plug), .mic(mic), .press(press),
                          .jack_in(jack_in), .jack_mic(jack_mic), .button_in(button_in));

  task summarize;
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  // Bus tasks leave an idle edge so a strobe is never raised as it drops
  task wr(input logic [7:0] a, input logic [7:0] w);
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1;
    @(posedge clk) #1 reg_wr = 0;
    @(posedge clk) #1;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] r);
    reg_addr = a;
    reg_rd = 1;
    @(posedge clk) #1 reg_rd = 0;
    `CHK(reg_rvalid, 1'b1)
    r = reg_rdata;
    @(posedge clk) #1;
  endtask : rd

  task idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : idle

  // Bounded wait for a detection result
  task wait_type(input logic [1:0] want, input int lim);
    while (headset_type !== want && lim > 0) begin
      @(posedge clk) #1;
      lim--;
    end
    idle(2);
    `CHK(headset_type, want)
    `CHK(headset_flag, want != CFHR_HS_NONE)
  endtask : wait_type

  initial begin
    idle(6);
    rst = 0;
    for (k = 12; k < 15; k++) begin
      rd(k[7:0], v);
      `CHK(v, 8'h00)
    end
    repeat (24) begin
      d = $random(seed);
      wr(CFHR_FILT_OFS, d);
      rd(CFHR_FILT_OFS, v);
      `CHK(v, d)
      `CHK({adc_hpf_left, adc_hpf_right, dac_fx_left, dac_deemph_left, dac_fx_right, dac_deemph_right}, d)
      e = d & 8'hc8;
      if (e[6]) e[3] = 1'b0;
      wr(CFHR_DETB_OFS, e | 8'h30);
      rd(CFHR_DETB_OFS, v);
      `CHK(v, e)
      `CHK({drv_ac_coupled, drv_full_diff, drv_pseudo_diff}, {e[7], e[6], e[3]})
      e = {1'b0, d[6:0]};
      if (e[4:2] > CFHR_JDEB_MAX) e[4] = 1'b0;
      wr(CFHR_DETA_OFS, e);
      rd(CFHR_DETA_OFS, v);
      `CHK(v, e & 8'h9f)
    end
    // Unmapped places neither store nor answer
    wr(8'h0b, 8'hff);
    wr(8'h0f, 8'hff);
    rd(CFHR_FILT_OFS, v);
    `CHK(v, d)
    rd(8'h0f, v);
    `CHK(v, 8'h00)
    plug = 1;
    mic = 1;
    idle(400);
    `CHK(headset_type, CFHR_HS_NONE)
    plug = 0;
    for (k = 0; k < 6; k++) begin
      t = MS << (k + 1);
      wr(CFHR_DETA_OFS, {1'b1, 2'b00, k[2:0], 2'b00});
      plug = 1;
      mic = k[0];
      idle(3 * t);
      plug = 0;
      idle(10 * t);
      `CHK(headset_flag, 1'b0)
      plug = 1;
      idle(6 * t);
      `CHK(headset_type, CFHR_HS_NONE)
      wait_type(k[0] ? CFHR_HS_MIC : CFHR_HS_NOMIC, 4 * t);
      plug = 0;
      wait_type(CFHR_HS_NONE, 10 * t);
    end
    plug = 1;
    mic = 1;
    wr(CFHR_DETA_OFS, 8'h80);
    wait_type(CFHR_HS_MIC, 10 * 2 * MS);
    for (k = 0; k < 4; k++) begin
      t = (k == 0) ? 1 : MS << (k - 1);
      wr(CFHR_DETA_OFS, {6'h20, k[1:0]});
      press = 1;
      idle(6 * t);
      if (k != 0) `CHK(button_flag, 1'b0)
      idle(4 * t + 2);
      `CHK(button_flag, 1'b1)
      press = 0;
      idle(10 * t + 2);
      rd(CFHR_DETB_OFS, v);
      `CHK(v[5:4], 2'b11)
      rd(CFHR_DETB_OFS, v);
      `CHK(v[5], 1'b0)
    end
    wr(CFHR_DETA_OFS, 8'h00);
    idle(4);
    `CHK(headset_flag, 1'b0)
    summarize();
  end
endmodule : tb_top
